//--- design/fault_sup_pkg.sv
// Purpose: shared constants for the power switch fault supervisor
// Assumes: 250 MHz core clock, 32-bit register port
// Notes:   times are kept in ns and turned into cycle counts here

package fault_sup_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int CLK_MHZ             = 250;
  localparam int NS_PER_US           = 1000;
  // command-low time that releases the short-circuit latch
  localparam int SC_RELEASE_TIME_NS  = 1000;
  localparam int SC_RELEASE_CYCLES   = (SC_RELEASE_TIME_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  // settle time before the overcurrent pin strap is sampled
  localparam int STRAP_SETTLE_NS     = 100;
  localparam int STRAP_SETTLE_CYCLES = (STRAP_SETTLE_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;

  // ************************************************************
  // register port
  // ************************************************************
  localparam int          REG_AW       = 4;
  localparam int          REG_DW       = 32;
  localparam logic [3:0]  ADDR_CTRL    = 4'h0;
  localparam logic [3:0]  ADDR_STATUS  = 4'h4;
  localparam logic [31:0] RDATA_IDLE   = 32'h00000000;

  // control register fields
  localparam int   CTRL_SW_EN_BIT  = 0;
  localparam int   CTRL_IDM_EN_BIT = 1;
  localparam logic CTRL_SW_EN_RST  = 1'b1;
  localparam logic CTRL_IDM_EN_RST = 1'b1;

  // status register fields
  localparam int ST_OVERCURRENT_BIT  = 0;
  localparam int ST_SHORT_BIT        = 1;
  localparam int ST_FET_OT_BIT       = 2;
  localparam int ST_DRV_OT_BIT       = 3;
  localparam int ST_LOCKOUT_BIT      = 4;
  localparam int ST_DRIVE_OPEN_BIT   = 5;
  localparam int ST_COMBINED_BIT     = 6;
  localparam int ST_GATE_BIT         = 7;
  localparam int ST_RUN_BIT          = 8;
  localparam int ST_IDM_BIT          = 9;

  // ************************************************************
  // supply sequencing
  // ************************************************************
  typedef enum logic [1:0] {
    ST_LOCKOUT,
    ST_STARTUP,
    ST_RUN
  } supply_state_e;

endpackage : fault_sup_pkg

//--- design/low_time_qualifier.sv
// Purpose: qualifies a level that has stayed low for a minimum time
// Assumes: input already in the clock domain
// Notes:   output falls the edge after the level goes high again

`timescale 1ns/100ps

module low_time_qualifier
  import fault_sup_pkg::*;
#(
  parameter int CYCLES = SC_RELEASE_CYCLES
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic hold_low,
  output logic      qualified
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count;

  // ************************************************************
  // low-time counter
  // ************************************************************
  // saturates so a very long low stays qualified
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      count     <= '0;
      qualified <= 1'b0;
    end
    else if (!hold_low)
    begin
      count     <= '0;
      qualified <= 1'b0;
    end
    else if (count == CW'(CYCLES - 1))
    begin
      qualified <= 1'b1;
    end
    else
    begin
      count <= count + CW'(1);
    end
  end

endmodule : low_time_qualifier

//--- design/power_switch_fault_supervisor.sv
// Purpose: protection gating and fault reporting of a power switch
// Assumes: detector flags are clock-synchronous; command and strap pins are not
// Notes:   analog sensing, thresholds and slew control live elsewhere
//
// The address-and-strobe port and the register offsets were decided locally.

`timescale 1ns/100ps

module power_switch_fault_supervisor
  import fault_sup_pkg::*;
#(
  parameter int SC_CYCLES    = SC_RELEASE_CYCLES,
  parameter int STRAP_CYCLES = STRAP_SETTLE_CYCLES
)
(
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire logic              SWITCH_CMD,
  input  wire logic              OVERCURRENT_GUARD,
  input  wire logic              SHORT_CIRCUIT_GUARD,
  input  wire logic              THERMAL_SHUTDOWN_FET,
  input  wire logic              THERMAL_SHUTDOWN_DRIVER,
  input  wire logic              SUPPLY_OK,
  input  wire logic              DRIVE_STRENGTH_SETTING_OPEN,
  input  wire logic              THIRD_QUADRANT,
  input  wire logic              SERIES_FET_ON,
  input  wire logic              OVERCURRENT_FLAG_IN,
  input  wire logic [REG_AW-1:0] REG_ADDR,
  input  wire logic [REG_DW-1:0] REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic      [REG_DW-1:0] REG_RDATA,
  output logic                   FET_GATE,
  output logic                   SLOW_TURNOFF,
  output logic                   AUXILIARY_REGULATOR_EN,
  output logic                   NEGATIVE_RAIL_EN,
  output logic                   FAULT_N,
  output logic                   OVERCURRENT_FLAG_OUT_N,
  output logic                   OVERCURRENT_FLAG_OE_N
);

  localparam int SW = $clog2(STRAP_CYCLES + 1);

  // ************************************************************
  // declarations
  // ************************************************************
  logic          cmd_meta;
  logic          cmd;
  logic          strap_meta;
  logic          strap_pin;
  logic [SW-1:0] strap_cnt;
  logic          strap_done;
  logic          combined;
  logic          supply_ok_q;
  logic          supply_rise;
  logic          supply_lockout;
  supply_state_e state;
  logic          rails_on;
  logic          overcurrent_active;
  logic          short_latch;
  logic          short_set;
  logic          overcurrent_set;
  logic          release_ok;
  logic          sw_enable;
  logic          idm_enable;
  logic          thermal_any;
  logic          thermal_ideal_diode_mode;
  logic          next_gate;
  logic          next_fault_n;
  logic          next_oc_n;
  logic [REG_DW-1:0] status_word;

  // set wins over clear for every hardware-set flag
  function automatic logic set_wins(input logic cur, input logic set, input logic clr);
    set_wins = set | (cur & ~clr);
  endfunction : set_wins

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      cmd_meta <= 1'b0;
      cmd      <= 1'b0;
    end
    else
    begin
      cmd_meta <= SWITCH_CMD;
      cmd      <= cmd_meta;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      strap_meta <= 1'b1;
      strap_pin  <= 1'b1;
    end
    else
    begin
      strap_meta <= OVERCURRENT_FLAG_IN;
      strap_pin  <= strap_meta;
    end
  end

  // ************************************************************
  // power-up strap of the overcurrent pin
  // ************************************************************
  // pin is released until sampled, so a hard ground is not fought
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      strap_cnt  <= '0;
      strap_done <= 1'b0;
      combined   <= 1'b0;
    end
    else if (!strap_done)
    begin
      if (strap_cnt == SW'(STRAP_CYCLES))
      begin
        strap_done <= 1'b1;
        combined   <= ~strap_pin;
      end
      else
      begin
        strap_cnt <= strap_cnt + SW'(1);
      end
    end
  end

  // ************************************************************
  // supply sequencing
  // ************************************************************
  assign supply_lockout = ~SUPPLY_OK;
  assign supply_rise    = SUPPLY_OK & ~supply_ok_q;

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      supply_ok_q <= 1'b0;
    end
    else
    begin
      supply_ok_q <= SUPPLY_OK;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      state <= ST_LOCKOUT;
    end
    else if (supply_lockout)
    begin
      state <= ST_LOCKOUT;
    end
    else
    begin
      unique case (state)
        ST_LOCKOUT:
        begin
          if (supply_rise)
          begin
            state <= ST_STARTUP;
          end
        end
        ST_STARTUP:
        begin
          if (SERIES_FET_ON)
          begin
            state <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  // rails come up on the edge out of lockout, drop with the supply
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      rails_on <= 1'b0;
    end
    else if (supply_rise)
    begin
      rails_on <= 1'b1;
    end
    else if (supply_lockout)
    begin
      rails_on <= 1'b0;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      AUXILIARY_REGULATOR_EN <= 1'b0;
      NEGATIVE_RAIL_EN       <= 1'b0;
    end
    else
    begin
      AUXILIARY_REGULATOR_EN <= (rails_on | supply_rise) & ~THERMAL_SHUTDOWN_DRIVER;
      NEGATIVE_RAIL_EN       <= (rails_on | supply_rise) & ~THERMAL_SHUTDOWN_DRIVER;
    end
  end

  // ************************************************************
  // current fault classification
  // ************************************************************
  // a tie in the same cycle counts as short-circuit: the fast path won
  assign short_set       = SHORT_CIRCUIT_GUARD & FET_GATE & ~overcurrent_active;
  assign overcurrent_set = OVERCURRENT_GUARD & ~SHORT_CIRCUIT_GUARD & FET_GATE & ~short_latch;

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      overcurrent_active <= 1'b0;
    end
    else
    begin
      overcurrent_active <= set_wins(overcurrent_active, overcurrent_set, ~cmd);
    end
  end

  // release needs the command held low, counted only while latched
  low_time_qualifier #(
    .CYCLES (SC_CYCLES)
  ) u_release (
    .clk       (CLK),
    .rst_n     (RST_N),
    .hold_low  (~cmd & short_latch),
    .qualified (release_ok)
  );

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      short_latch <= 1'b0;
    end
    else
    begin
      short_latch <= set_wins(short_latch, short_set, release_ok | supply_lockout);
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      SLOW_TURNOFF <= 1'b0;
    end
    else
    begin
      SLOW_TURNOFF <= short_set | short_latch;
    end
  end

  // ************************************************************
  // switch gating
  // ************************************************************
  assign thermal_any              = THERMAL_SHUTDOWN_FET | THERMAL_SHUTDOWN_DRIVER;
  assign thermal_ideal_diode_mode = THERMAL_SHUTDOWN_FET & ~THERMAL_SHUTDOWN_DRIVER;

  // raw flags feed the gate so protection lands on the next edge
  always_comb
  begin
    next_gate = 1'b0;
    if (state == ST_RUN && !supply_lockout && strap_done && !THERMAL_SHUTDOWN_DRIVER)
    begin
      if (thermal_ideal_diode_mode)
      begin
        next_gate = THIRD_QUADRANT & idm_enable & ~short_latch & ~SHORT_CIRCUIT_GUARD;
      end
      else
      begin
        next_gate = cmd & sw_enable & ~short_latch & ~overcurrent_active
                  & ~OVERCURRENT_GUARD & ~SHORT_CIRCUIT_GUARD;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      FET_GATE <= 1'b0;
    end
    else
    begin
      FET_GATE <= next_gate;
    end
  end

  // ************************************************************
  // fault reporting
  // ************************************************************
  // single-pin mode folds overcurrent into the fault output
  always_comb
  begin
    next_fault_n = 1'b1;
    next_oc_n    = 1'b1;
    if (state != ST_RUN || supply_lockout)
    begin
      next_fault_n = 1'b0;
    end
    if (thermal_any)
    begin
      next_fault_n = 1'b0;
    end
    if (DRIVE_STRENGTH_SETTING_OPEN)
    begin
      next_fault_n = 1'b0;
    end
    if (short_latch)
    begin
      next_fault_n = 1'b0;
      next_oc_n    = 1'b0;
    end
    if (overcurrent_active)
    begin
      next_oc_n = 1'b0;
      if (combined)
      begin
        next_fault_n = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      FAULT_N                <= 1'b0;
      OVERCURRENT_FLAG_OUT_N <= 1'b1;
      OVERCURRENT_FLAG_OE_N  <= 1'b1;
    end
    else
    begin
      FAULT_N                <= next_fault_n;
      OVERCURRENT_FLAG_OUT_N <= next_oc_n;
      OVERCURRENT_FLAG_OE_N  <= ~strap_done | combined;
    end
  end

  // ************************************************************
  // register port
  // ************************************************************
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      sw_enable  <= CTRL_SW_EN_RST;
      idm_enable <= CTRL_IDM_EN_RST;
    end
    else if (REG_WR && REG_ADDR == ADDR_CTRL)
    begin
      sw_enable  <= REG_WDATA[CTRL_SW_EN_BIT];
      idm_enable <= REG_WDATA[CTRL_IDM_EN_BIT];
    end
  end

  always_comb
  begin
    status_word                     = '0;
    status_word[ST_OVERCURRENT_BIT] = overcurrent_active;
    status_word[ST_SHORT_BIT]       = short_latch;
    status_word[ST_FET_OT_BIT]      = THERMAL_SHUTDOWN_FET;
    status_word[ST_DRV_OT_BIT]      = THERMAL_SHUTDOWN_DRIVER;
    status_word[ST_LOCKOUT_BIT]     = supply_lockout;
    status_word[ST_DRIVE_OPEN_BIT]  = DRIVE_STRENGTH_SETTING_OPEN;
    status_word[ST_COMBINED_BIT]    = combined;
    status_word[ST_GATE_BIT]        = FET_GATE;
    status_word[ST_RUN_BIT]         = (state == ST_RUN);
    status_word[ST_IDM_BIT]         = thermal_ideal_diode_mode;
  end

  // data stands one cycle only; unmapped reads give zero
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      REG_RDATA <= RDATA_IDLE;
    end
    else if (REG_RD && REG_ADDR == ADDR_CTRL)
    begin
      REG_RDATA <= {{(REG_DW-2){1'b0}}, idm_enable, sw_enable};
    end
    else if (REG_RD && REG_ADDR == ADDR_STATUS)
    begin
      REG_RDATA <= status_word;
    end
    else
    begin
      REG_RDATA <= RDATA_IDLE;
    end
  end

endmodule : power_switch_fault_supervisor

//--- testbench/fault_sup_props.sv
// Purpose: port-level checks of the power switch fault supervisor
// Assumes: one clock, synchronous active-low reset
// Notes:   latched reports land two edges after their flag, level faults one

`timescale 1ns/100ps

module fault_sup_props
#(
  parameter int SC_CYCLES    = 4,
  parameter int STRAP_CYCLES = 2
)
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SUPPLY_OK,
  input wire logic OVERCURRENT_GUARD,
  input wire logic SHORT_CIRCUIT_GUARD,
  input wire logic THERMAL_SHUTDOWN_FET,
  input wire logic THERMAL_SHUTDOWN_DRIVER,
  input wire logic THIRD_QUADRANT,
  input wire logic FET_GATE,
  input wire logic SLOW_TURNOFF,
  input wire logic AUXILIARY_REGULATOR_EN,
  input wire logic NEGATIVE_RAIL_EN,
  input wire logic FAULT_N,
  input wire logic OVERCURRENT_FLAG_OUT_N,
  input wire logic OVERCURRENT_FLAG_OE_N
);
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  // ****************************************
  // protection and reporting
  // ****************************************
  // hot die left out: ideal-diode gating may own the gate then
  sequence oc_hit;
    OVERCURRENT_GUARD && !SHORT_CIRCUIT_GUARD && FET_GATE && !THERMAL_SHUTDOWN_FET;
  endsequence
  sequence short_hit;
    SHORT_CIRCUIT_GUARD && FET_GATE;
  endsequence

  AST_OC_OFF: assert property (oc_hit |=> !FET_GATE && !SLOW_TURNOFF)
    else $error("overcurrent left the switch on");
  AST_OC_REPORT: assert property (oc_hit |-> ##2 (OVERCURRENT_FLAG_OE_N ? !FAULT_N : !OVERCURRENT_FLAG_OUT_N))
    else $error("overcurrent not reported");
  AST_SC_OFF: assert property (short_hit |=> !FET_GATE && SLOW_TURNOFF)
    else $error("short not turned off slowly");
  AST_SC_REPORT: assert property (short_hit |-> ##2
    !FAULT_N && (OVERCURRENT_FLAG_OE_N || !OVERCURRENT_FLAG_OUT_N))
    else $error("short not reported");
  AST_SC_LATCH: assert property (SLOW_TURNOFF |-> !FET_GATE)
    else $error("switch on while short latched");
  AST_DRV_OT: assert property (THERMAL_SHUTDOWN_DRIVER |=> !FET_GATE)
    else $error("driver overheat left switch on");
  AST_OT_FAULT: assert property ((THERMAL_SHUTDOWN_FET || THERMAL_SHUTDOWN_DRIVER) |=> !FAULT_N)
    else $error("overheat not reported");
  AST_LOCKOUT: assert property (!SUPPLY_OK |=> !FET_GATE ##1 !FAULT_N)
    else $error("lockout not honoured");
  AST_IDM_BLOCK: assert property (THERMAL_SHUTDOWN_FET && !THIRD_QUADRANT |=> !FET_GATE)
    else $error("hot die conducted forward current");
  AST_RAILS_UP: assert property ($rose(SUPPLY_OK) && !THERMAL_SHUTDOWN_DRIVER |->
    ##[1:3] (AUXILIARY_REGULATOR_EN && NEGATIVE_RAIL_EN))
    else $error("rails not enabled after lockout");
endmodule : fault_sup_props

bind power_switch_fault_supervisor fault_sup_props #(.SC_CYCLES(SC_CYCLES), .STRAP_CYCLES(STRAP_CYCLES))
  fault_sup_props_i (
  .CLK(CLK), .RST_N(RST_N), .SUPPLY_OK(SUPPLY_OK), .OVERCURRENT_GUARD(OVERCURRENT_GUARD),
  .SHORT_CIRCUIT_GUARD(SHORT_CIRCUIT_GUARD), .THERMAL_SHUTDOWN_FET(THERMAL_SHUTDOWN_FET),
  .THERMAL_SHUTDOWN_DRIVER(THERMAL_SHUTDOWN_DRIVER), .THIRD_QUADRANT(THIRD_QUADRANT), .FET_GATE(FET_GATE),
  .SLOW_TURNOFF(SLOW_TURNOFF), .AUXILIARY_REGULATOR_EN(AUXILIARY_REGULATOR_EN), .NEGATIVE_RAIL_EN(NEGATIVE_RAIL_EN),
  .FAULT_N(FAULT_N), .OVERCURRENT_FLAG_OUT_N(OVERCURRENT_FLAG_OUT_N), .OVERCURRENT_FLAG_OE_N(OVERCURRENT_FLAG_OE_N));

//--- testbench/supply_controller_model.sv
// Purpose: power supply controller on the far side of the supervisor
// Assumes: command changes only right after a clock edge
// Notes:   kind 0 normal, 1 overcurrent, 2 short, 3 other fault

`timescale 1ns/100ps

module supply_controller_model
(
  input  wire logic       clk,
  input  wire logic       cmd_req,
  input  wire logic       strap_gnd,
  input  wire logic       fault_n,
  input  wire logic       oc_out_n,
  input  wire logic       oc_oe_n,
  output logic            switch_cmd,
  output wire logic       oc_pin,
  output logic      [1:0] kind
);
  // ****************************************
  // command and pin decode
  // ****************************************
  always @(posedge clk) switch_cmd <= cmd_req;
  // grounded strap wins; an undriven pin rises through the pull-up
  assign oc_pin = strap_gnd ? 1'h0 : (oc_oe_n ? 1'h1 : oc_out_n);
  always_comb
  begin
    if (strap_gnd)
      kind = fault_n ? 2'h0 : 2'h3;
    else
      kind = {!fault_n, fault_n ^ oc_pin};
  end
endmodule : supply_controller_model

//--- testbench/tb_top.sv
// Purpose: self-checking bench for the power switch fault supervisor
// Assumes: short release and strap counts cut to small values
// Notes:   the controller model drives the command and decodes the pins

`timescale 1ns/100ps

module tb_top
  import fault_sup_pkg::*;
;
  localparam int SC_P = 4;
  typedef struct {
    logic       sup, fot, dot, opn, q, gate, flt;
    logic [1:0] kind;
  } row_s;
  logic              clk, rst_n, switch_cmd, oc_guard, sc_guard, fet_ot, drv_ot, supply_ok, drv_open, tq;
  logic              series_on, oc_pin, cmd_req, strap_gnd, reg_wr, reg_rd, gate, slow, aux, neg, fault_n;
  logic              oc_n, oc_oe_n;
  logic [REG_AW-1:0] reg_addr;
  logic [REG_DW-1:0] reg_wdata, rdata;
  logic [1:0]        kind;
  int                fail_count = 0, n_compared = 0, cycles = 0;
  // supply, die hot, driver hot, drive open, reverse current -> gate, fault_n, kind
  row_s rows [6] = '{
    '{1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 2'h0},
    '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 2'h3},
    '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 2'h3},
    '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 2'h3},
    '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 2'h3},
    '{1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 2'h3}};

  power_switch_fault_supervisor #(.SC_CYCLES(SC_P), .STRAP_CYCLES(2)) power_switch_fault_supervisor_i (
    .CLK(clk), .RST_N(rst_n), .SWITCH_CMD(switch_cmd), .OVERCURRENT_GUARD(oc_guard), .SHORT_CIRCUIT_GUARD(sc_guard),
    .THERMAL_SHUTDOWN_FET(fet_ot), .THERMAL_SHUTDOWN_DRIVER(drv_ot), .SUPPLY_OK(supply_ok), .THIRD_QUADRANT(tq),
    .DRIVE_STRENGTH_SETTING_OPEN(drv_open), .SERIES_FET_ON(series_on), .OVERCURRENT_FLAG_IN(oc_pin),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata),
    .FET_GATE(gate), .SLOW_TURNOFF(slow), .AUXILIARY_REGULATOR_EN(aux), .NEGATIVE_RAIL_EN(neg),
    .FAULT_N(fault_n), .OVERCURRENT_FLAG_OUT_N(oc_n), .OVERCURRENT_FLAG_OE_N(oc_oe_n));
  supply_controller_model supply_controller_model_i (
    .clk(clk), .cmd_req(cmd_req), .strap_gnd(strap_gnd), .fault_n(fault_n), .oc_out_n(oc_n),
    .oc_oe_n(oc_oe_n), .switch_cmd(switch_cmd), .oc_pin(oc_pin), .kind(kind));

  // ****************************************
  // tasks
  // ****************************************
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("mismatch %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask : check
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  // one-cycle detector pulse
  task automatic hit(input logic o, input logic s);
    @(posedge clk);
    oc_guard <= o;
    sc_guard <= s;
    @(posedge clk);
    oc_guard <= 1'h0;
    sc_guard <= 1'h0;
    #1;
  endtask : hit
  task automatic cmd(input logic v, input int n);
    @(posedge clk);
    cmd_req <= v;
    step(n);
  endtask : cmd
  task automatic wait_run;
    for (int i = 0; i < 100 && fault_n !== 1'h1; i++)
      step(1);
    check("run", fault_n, 1'h1);
  endtask : wait_run
  task automatic reg_wr_op(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask : reg_wr_op
  task automatic reg_rd_op(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    check("rdata", rdata, e);
  endtask : reg_rd_op

  // ****************************************
  // clock, timeout and sequence
  // ****************************************
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // a hang is cut short here; normal run is well under a thousand cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      fail_count++;
      print_verdict();
    end
  end
  initial
  begin
    {rst_n, oc_guard, sc_guard, fet_ot, drv_ot, drv_open, tq, series_on, reg_wr, reg_rd, strap_gnd} = '0;
    {supply_ok, cmd_req} = 2'h3;
    reg_addr = '0;
    reg_wdata = '0;
    step(5);
    check("gate", gate, 1'h0);
    check("fault", fault_n, 1'h0);
    check("oc", oc_n, 1'h1);
    check("oe", oc_oe_n, 1'h1);
    check("rdata", rdata, '0);
    @(posedge clk);
    rst_n <= 1'h1;
    step(12);
    check("fault", fault_n, 1'h0);
    check("gate", gate, 1'h0);
    check("aux", aux, 1'h1);
    check("oe", oc_oe_n, 1'h0);
    @(posedge clk);
    series_on <= 1'h1;
    wait_run();
    step(6);
    foreach (rows[i])
    begin
      @(posedge clk);
      {supply_ok, fet_ot, drv_ot, drv_open, tq} <= {rows[i].sup, rows[i].fot, rows[i].dot, rows[i].opn, rows[i].q};
      step(6);
      check("gate", gate, rows[i].gate);
      check("fault", fault_n, rows[i].flt);
      check("kind", kind, rows[i].kind);
      @(posedge clk);
      {supply_ok, fet_ot, drv_ot, drv_open, tq} <= 5'h10;
      wait_run();
      step(6);
    end
    // overcurrent, then a late short that must not count as one
    hit(1'h1, 1'h0);
    check("gate", gate, 1'h0);
    hit(1'h0, 1'h1);
    step(6);
    check("slow", slow, 1'h0);
    check("kind", kind, 2'h1);
    check("gate", gate, 1'h0);
    cmd(1'h0, 8);
    check("kind", kind, 2'h0);
    cmd(1'h1, 8);
    check("gate", gate, 1'h1);
    // short: a brief low command must not release the latch
    hit(1'h0, 1'h1);
    check("slow", slow, 1'h1);
    step(2);
    check("kind", kind, 2'h2);
    cmd(1'h0, 1);
    cmd(1'h1, 8);
    check("slow", slow, 1'h1);
    check("gate", gate, 1'h0);
    cmd(1'h0, SC_P + 8);
    check("kind", kind, 2'h0);
    cmd(1'h1, 8);
    check("gate", gate, 1'h1);
    hit(1'h1, 1'h1);
    check("slow", slow, 1'h1);
    @(posedge clk);
    supply_ok <= 1'h0;
    step(2);
    @(posedge clk);
    supply_ok <= 1'h1;
    wait_run();
    step(6);
    check("slow", slow, 1'h0);
    check("gate", gate, 1'h1);
    // both hot, then the driver cools first
    @(posedge clk);
    {fet_ot, drv_ot, tq} <= 3'h7;
    step(4);
    check("gate", gate, 1'h0);
    check("rail", neg, 1'h0);
    @(posedge clk);
    drv_ot <= 1'h0;
    step(4);
    check("gate", gate, 1'h1);
    check("aux", aux, 1'h1);
    check("fault", fault_n, 1'h0);
    @(posedge clk);
    {fet_ot, tq} <= 2'h0;
    step(4);
    check("fault", fault_n, 1'h1);
    reg_rd_op(ADDR_CTRL, 32'h3);
    reg_rd_op(ADDR_STATUS, 32'h180);
    reg_wr_op(ADDR_CTRL, 32'h0);
    reg_wr_op(4'h8, 32'h3);
    reg_rd_op(4'h8, 32'h0);
    reg_rd_op(ADDR_CTRL, 32'h0);
    check("gate", gate, 1'h0);
    reg_wr_op(ADDR_CTRL, 32'h3);
    step(6);
    check("gate", gate, 1'h1);
    // ideal-diode allow bit cleared keeps a hot die off
    reg_wr_op(ADDR_CTRL, 32'h1);
    @(posedge clk);
    {fet_ot, tq} <= 2'h3;
    step(4);
    check("gate", gate, 1'h0);
    reg_rd_op(ADDR_STATUS, 32'h304);
    @(posedge clk);
    {fet_ot, tq} <= 2'h0;
    reg_wr_op(ADDR_CTRL, 32'h3);
    // strap grounded across a fresh reset selects single-pin reporting
    @(posedge clk);
    rst_n <= 1'h0;
    strap_gnd <= 1'h1;
    step(3);
    @(posedge clk);
    rst_n <= 1'h1;
    wait_run();
    step(6);
    hit(1'h1, 1'h0);
    step(2);
    check("fault", fault_n, 1'h0);
    check("oe", oc_oe_n, 1'h1);
    check("kind", kind, 2'h3);
    check("gate", gate, 1'h0);
    print_verdict();
  end
endmodule : tb_top
